// [design/pcmp_top.sv]
// How it works
// - The management clock is foreign to every other clock and is synchronised before use.
// - The management data line is shared and this end only pulls it low or lets it go.
// - By default the interrupt pin is pulled low while any enabled event flag is set.
// - An event only sets its flag once software has enabled it in the configuration register.
// - A set event flag stays set until software clears it by writing a one to it.
// - A bit of the configuration register at 0x11 turns the interrupt pin active high.
// - A mode bit at 0x11 makes the interrupt pin a power-down input, low meaning powered down.
// - Pulling the reset pin low for any length of time starts a full reset sequence that lasts at least 1 us after release.
// - Reset returns every register to its default value.
// - The strap pins are captured anew once reset is released.
`include "pcmp_defines.svh"

module pcmp_top (
	input wire logic REF_CLK,
	input wire logic RESET_N,
	input wire logic CE,
	input wire logic MDC,
	input wire logic MDIO_IN,
	output logic MDIO_OUT,
	output logic MDIO_OE,
	input wire logic INT_IN,
	output logic INT_OUT,
	output logic INT_OE,
	input wire logic [7:0] STRAP,
	input wire logic [3:0] EVENT,
	output logic POWER_DOWN,
	output logic [7:0] STRAP_VAL,
	output logic READY
);
	pcmp_pkg::pcmp_top_s st;
	pcmp_pkg::pcmp_top_s next_st;
	pcmp_regbus_if bus ();

	logic [3:0] evt_en;
	logic [3:0] evt_hit;
	logic [3:0] clr_mask;
	logic clr_wr;
	logic irq;
	logic pol_high;
	logic pd_mode;

	pcmp_mdio_frame u_frame (
		.clk(REF_CLK),
		.rst_n(RESET_N),
		.ce(CE),
		.bus(bus)
	);

	assign evt_en = st.cfg[`PCMP_CFG_EN_LSB +: `PCMP_NUM_EVT];
	assign evt_hit = EVENT & evt_en;
	assign clr_wr = bus.wr && (bus.addr == `PCMP_REG_INT_FLAG);
	assign clr_mask = clr_wr ? bus.wdata[3:0] : 4'h0;
	assign irq = |(st.flags & evt_en);
	assign pol_high = st.cfg[`PCMP_CFG_POL_BIT];
	assign pd_mode = st.cfg[`PCMP_CFG_PD_BIT];

	assign bus.mdc_rise = st.mdc_s2 & ~st.mdc_d & st.ready;
	assign bus.mdio_bit = st.mdio_s2;
	assign bus.rdata = st.rdata;
	assign bus.phy_addr = st.strap_cap[4:0];

	assign MDIO_OUT = 1'b0;
	assign MDIO_OE = bus.mdio_oe;
	assign INT_OUT = 1'b0;
	assign INT_OE = st.int_oe;
	assign POWER_DOWN = st.pd;
	assign STRAP_VAL = st.strap_cap;
	assign READY = st.ready;

	always_comb begin
		next_st = st;
		next_st.mdc_s1 = MDC;
		next_st.mdc_s2 = st.mdc_s1;
		next_st.mdc_d = st.mdc_s2;
		next_st.mdio_s1 = MDIO_IN;
		next_st.mdio_s2 = st.mdio_s1;
		next_st.int_s1 = INT_IN;
		next_st.int_s2 = st.int_s1;
		next_st.strap_s1 = STRAP;
		next_st.strap_s2 = st.strap_s1;
		if (!st.ready) begin
			if (st.rst_cnt == `PCMP_SYNC_DEPTH) begin
				next_st.strap_cap = st.strap_s2;
			end
			if (st.rst_cnt == 4'(`PCMP_RESET_MIN_CYC)) begin
				next_st.ready = 1'b1;
			end else begin
				next_st.rst_cnt = st.rst_cnt + 4'h1;
			end
		end
		if (bus.wr && bus.addr == `PCMP_REG_INT_CFG) begin
			next_st.cfg = bus.wdata;
		end
		next_st.flags = (st.flags & ~clr_mask) | evt_hit;
		if (bus.rd) begin
			case (bus.addr)
				`PCMP_REG_INT_CFG: begin
					next_st.rdata = st.cfg;
				end
				`PCMP_REG_INT_FLAG: begin
					next_st.rdata = {12'h000, st.flags};
				end
				`PCMP_REG_STRAP: begin
					next_st.rdata = {8'h00, st.strap_cap};
				end
				default: begin
					next_st.rdata = 16'h0000;
				end
			endcase
		end
		next_st.int_oe = pd_mode ? 1'b0 : (irq ^ pol_high);
		next_st.pd = pd_mode & ~st.int_s2;
	end

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			st <= '{cfg: `PCMP_CFG_RESET, default: '0};
		end else if (CE) begin
			st <= next_st;
		end
	end

	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RESET_N);

	chk_flag_set_enabled: assert property (
		CE && (evt_hit != 4'h0) |=> (st.flags & $past(evt_hit)) == $past(evt_hit))
		else $error("Enabled event did not set its flag.");
	chk_flag_needs_enable: assert property (
		CE |=> (st.flags & ~$past(st.flags) & ~$past(evt_hit)) == 4'h0)
		else $error("Flag rose without an enabled event.");
	chk_flag_sticky: assert property (
		CE && !clr_wr |=> (st.flags & $past(st.flags)) == $past(st.flags))
		else $error("Flag cleared without a software clear.");
	chk_set_beats_clear: assert property (
		CE && clr_wr && (evt_hit != 4'h0) |=> (st.flags & $past(evt_hit)) == $past(evt_hit))
		else $error("Clear won over a simultaneous event.");
	chk_int_active_low: assert property (
		CE && irq && !pol_high && !pd_mode |=> INT_OE && !INT_OUT)
		else $error("Interrupt pin not pulled low on a pending event.");
	chk_int_active_high: assert property (
		CE && pol_high && !pd_mode |=> INT_OE == !$past(irq))
		else $error("Active high interrupt level wrong.");
	chk_int_release: assert property (
		CE && !irq && !pol_high && !pd_mode |=> !INT_OE)
		else $error("Interrupt pin held after all flags cleared.");
	chk_pd_input: assert property (
		CE && pd_mode |=> !INT_OE && (POWER_DOWN == !$past(st.int_s2)))
		else $error("Power-down input mode misbehaves.");
	chk_cfg_default: assert property (
		!st.ready |-> st.cfg == `PCMP_CFG_RESET && st.flags == 4'h0)
		else $error("Register left its default during reset sequence.");
	chk_strap_capture: assert property (
		CE && !st.ready && st.rst_cnt == `PCMP_SYNC_DEPTH |=> STRAP_VAL == $past(st.strap_s2))
		else $error("Straps not captured after reset release.");
	chk_ready_time: assert property (
		!st.ready && CE && st.rst_cnt == 4'(`PCMP_RESET_MIN_CYC) |=> READY ##0 $past(!READY))
		else $error("Reset sequence length wrong.");

	cov_flag_set: cover property (CE && evt_hit != 4'h0 ##1 INT_OE);
	cov_power_down: cover property (pd_mode ##1 POWER_DOWN);
	cov_clear_flag: cover property (clr_wr && st.flags != 4'h0);

endmodule : pcmp_top

// [design/pcmp_defines.svh]
`ifndef PCMP_DEFINES_SVH
`define PCMP_DEFINES_SVH

`define PCMP_REG_INT_CFG 5'h11
`define PCMP_REG_INT_FLAG 5'h12
`define PCMP_REG_STRAP 5'h13
`define PCMP_CFG_RESET 16'h0000
`define PCMP_CFG_POL_BIT 0
`define PCMP_CFG_PD_BIT 1
`define PCMP_CFG_EN_LSB 8
`define PCMP_NUM_EVT 4
`define PCMP_STRAP_W 8
`define PCMP_OP_READ 2'h2
`define PCMP_OP_WRITE 2'h1
`define PCMP_PRE_BITS 6'h20
`define PCMP_HDR_LAST 6'h0c
`define PCMP_DATA_LAST 6'h0f
`define PCMP_SYNC_DEPTH 4'h2
`define PCMP_CLK_PERIOD_NS 100
`define PCMP_RESET_MIN_NS 1000
`define PCMP_RESET_MIN_CYC \
	((`PCMP_RESET_MIN_NS + `PCMP_CLK_PERIOD_NS - 1) / `PCMP_CLK_PERIOD_NS)

`endif

// [design/pcmp_pkg.sv]
package pcmp_pkg;

	typedef enum logic [3:0] {
		PCMP_PRE = 4'h1,
		PCMP_HDR = 4'h2,
		PCMP_TA = 4'h4,
		PCMP_DATA = 4'h8
	} pcmp_frame_e;

	typedef struct packed {
		pcmp_frame_e state;
		logic [5:0] cnt;
		logic [15:0] shift;
		logic [4:0] addr;
		logic op_read;
		logic mdio_oe;
		logic wr;
		logic rd;
	} pcmp_frame_s;

	typedef struct packed {
		logic mdc_s1;
		logic mdc_s2;
		logic mdc_d;
		logic mdio_s1;
		logic mdio_s2;
		logic int_s1;
		logic int_s2;
		logic [7:0] strap_s1;
		logic [7:0] strap_s2;
		logic [7:0] strap_cap;
		logic [3:0] rst_cnt;
		logic ready;
		logic [15:0] cfg;
		logic [3:0] flags;
		logic [15:0] rdata;
		logic int_oe;
		logic pd;
	} pcmp_top_s;

endpackage : pcmp_pkg

// [design/pcmp_regbus_if.sv]
interface pcmp_regbus_if;
	logic mdc_rise;
	logic mdio_bit;
	logic [15:0] rdata;
	logic [4:0] phy_addr;
	logic [4:0] addr;
	logic [15:0] wdata;
	logic wr;
	logic rd;
	logic mdio_oe;

	modport frame (
		input mdc_rise, mdio_bit, rdata, phy_addr,
		output addr, wdata, wr, rd, mdio_oe
	);

	modport regs (
		output mdc_rise, mdio_bit, rdata, phy_addr,
		input addr, wdata, wr, rd, mdio_oe
	);
endinterface : pcmp_regbus_if

// [design/pcmp_mdio_frame.sv]
`include "pcmp_defines.svh"

module pcmp_mdio_frame (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	pcmp_regbus_if.frame bus
);
	pcmp_pkg::pcmp_frame_s st;
	pcmp_pkg::pcmp_frame_s next_st;
	logic [12:0] hdr;
	logic hdr_ok;

	assign bus.addr = st.addr;
	assign bus.wdata = st.shift;
	assign bus.wr = st.wr;
	assign bus.rd = st.rd;
	assign bus.mdio_oe = st.mdio_oe;
	assign hdr = {st.shift[11:0], bus.mdio_bit};
	assign hdr_ok = hdr[12] && (hdr[9:5] == bus.phy_addr) &&
		(hdr[11:10] == `PCMP_OP_READ || hdr[11:10] == `PCMP_OP_WRITE);

	always_comb begin
		next_st = st;
		next_st.wr = 1'b0;
		next_st.rd = 1'b0;
		if (bus.mdc_rise) begin
			case (st.state)
				pcmp_pkg::PCMP_PRE: begin
					if (bus.mdio_bit) begin
						if (st.cnt != `PCMP_PRE_BITS) begin
							next_st.cnt = st.cnt + 6'h01;
						end
					end else if (st.cnt == `PCMP_PRE_BITS) begin
						next_st.state = pcmp_pkg::PCMP_HDR;
						next_st.cnt = 6'h00;
						next_st.shift = 16'h0000;
					end else begin
						next_st.cnt = 6'h00;
					end
				end
				pcmp_pkg::PCMP_HDR: begin
					next_st.shift = {st.shift[14:0], bus.mdio_bit};
					next_st.cnt = st.cnt + 6'h01;
					if (st.cnt == `PCMP_HDR_LAST) begin
						next_st.cnt = 6'h00;
						next_st.addr = hdr[4:0];
						next_st.op_read = (hdr[11:10] == `PCMP_OP_READ);
						next_st.state = hdr_ok ? pcmp_pkg::PCMP_TA : pcmp_pkg::PCMP_PRE;
						next_st.rd = hdr_ok && (hdr[11:10] == `PCMP_OP_READ);
					end
				end
				pcmp_pkg::PCMP_TA: begin
					if (st.cnt == 6'h00) begin
						next_st.cnt = 6'h01;
						next_st.mdio_oe = st.op_read;
					end else begin
						next_st.state = pcmp_pkg::PCMP_DATA;
						next_st.cnt = 6'h00;
						if (st.op_read) begin
							next_st.mdio_oe = ~bus.rdata[15];
							next_st.shift = {bus.rdata[14:0], 1'b0};
						end
					end
				end
				pcmp_pkg::PCMP_DATA: begin
					next_st.cnt = st.cnt + 6'h01;
					if (st.op_read) begin
						next_st.mdio_oe = ~st.shift[15];
						next_st.shift = {st.shift[14:0], 1'b0};
					end else begin
						next_st.shift = {st.shift[14:0], bus.mdio_bit};
					end
					if (st.cnt == `PCMP_DATA_LAST) begin
						next_st.state = pcmp_pkg::PCMP_PRE;
						next_st.cnt = 6'h00;
						next_st.mdio_oe = 1'b0;
						next_st.wr = ~st.op_read;
					end
				end
				default: begin
					next_st.state = pcmp_pkg::PCMP_PRE;
					next_st.cnt = 6'h00;
					next_st.mdio_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '{state: pcmp_pkg::PCMP_PRE, default: '0};
		end else if (ce) begin
			st <= next_st;
		end
	end

	chk_od_read_only: assert property (@(posedge clk) disable iff (!rst_n)
		st.mdio_oe |-> st.op_read &&
			(st.state == pcmp_pkg::PCMP_TA || st.state == pcmp_pkg::PCMP_DATA))
		else $error("Data line driven outside a read answer.");
	chk_write_end: assert property (@(posedge clk) disable iff (!rst_n)
		st.wr |-> $past(st.state) == pcmp_pkg::PCMP_DATA && st.state == pcmp_pkg::PCMP_PRE)
		else $error("Write strobe outside the end of a frame.");
	cov_read_frame: cover property (@(posedge clk) disable iff (!rst_n) st.rd);
	cov_write_frame: cover property (@(posedge clk) disable iff (!rst_n) st.wr);

endmodule : pcmp_mdio_frame

// [tb/pcmp_station.sv]
module pcmp_station (
	input wire logic clk,
	input wire logic dut_oe,
	output logic mdc,
	output logic mdio
);
	timeunit 1ns;
	timeprecision 1ns;
	logic sta_low;
	// Both ends only pull low; the pull-up gives a one when both let go.
	assign mdio = !(sta_low || dut_oe);
	initial begin
		mdc = 1'b0;
		sta_low = 1'b0;
	end
	// One whole frame; the clock rests low outside it and the last 16 samples are the data.
	task automatic xfer(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rdat);
		logic [63:0] bits;
		bits = {32'hffffffff, 2'b01, rd ? 2'b10 : 2'b01, pa, ra, rd ? 2'b11 : 2'b10,
			rd ? 16'hffff : wd};
		for (int i = 63; i >= 0; i--) begin
			sta_low = !bits[i];
			repeat (5) @(negedge clk);
			rdat = {rdat[14:0], mdio};
			mdc = 1'b1;
			repeat (5) @(negedge clk);
			mdc = 1'b0;
		end
		sta_low = 1'b0;
	endtask : xfer
endmodule : pcmp_station

// [tb/tb.sv]
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic int_ext = 1'b1;
	logic [7:0] strap = 8'h25;
	logic [3:0] event_in = 4'h0;
	logic mdc;
	logic mdio;
	logic mdio_oe;
	logic int_oe;
	logic power_down;
	logic ready;
	logic [7:0] strap_val;
	logic [15:0] rd;
	int fails = 0;
	int n_checks = 0;
	int cycles = 0;

	always #50 ref_clk = !ref_clk;

	pcmp_station i_sta (.clk(ref_clk), .dut_oe(mdio_oe), .mdc(mdc), .mdio(mdio));

	pcmp_top i_dut (.REF_CLK(ref_clk), .RESET_N(reset_n), .CE(1'b1), .MDC(mdc),
		.MDIO_IN(mdio), .MDIO_OUT(), .MDIO_OE(mdio_oe), .INT_IN(!int_oe && int_ext),
		.INT_OUT(), .INT_OE(int_oe), .STRAP(strap), .EVENT(event_in),
		.POWER_DOWN(power_down), .STRAP_VAL(strap_val), .READY(ready));

	task automatic conclude();
		$display("checks %0d, mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : conclude

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 30000) begin
			fails++;
			conclude();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : tick

	task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
		i_sta.xfer(1'b0, strap[4:0], ra, wd, rd);
		tick(4);
	endtask : wr

	task automatic rdreg(input logic [4:0] ra);
		i_sta.xfer(1'b1, strap[4:0], ra, 16'h0000, rd);
	endtask : rdreg

	task automatic pulse();
		event_in = 4'h1;
		tick(1);
		event_in = 4'h0;
		tick(3);
	endtask : pulse

	task automatic do_reset(input logic [7:0] s);
		reset_n = 1'b0;
		strap = s;
		tick(12);
		reset_n = 1'b1;
		tick(14);
		check(ready, 1'b1);
	endtask : do_reset

	task automatic t_reset();
		do_reset(8'h25);
		check(strap_val, 8'h25);
		check(int_oe, 1'b0);
		check(mdio_oe, 1'b0);
		rdreg(5'h11);
		check(rd, 16'h0000);
		rdreg(5'h13);
		check(rd, 16'h0025);
	endtask : t_reset

	task automatic t_enable();
		pulse();
		check(int_oe, 1'b0);
		rdreg(5'h12);
		check(rd, 16'h0000);
		wr(5'h11, 16'h0100);
		pulse();
		check(int_oe, 1'b1);
		tick(200);
		check(int_oe, 1'b1);
		rdreg(5'h12);
		check(rd, 16'h0001);
		wr(5'h12, 16'h0001);
		check(int_oe, 1'b0);
		rdreg(5'h12);
		check(rd, 16'h0000);
	endtask : t_enable

	task automatic t_polarity();
		wr(5'h11, 16'h0101);
		check(int_oe, 1'b1);
		pulse();
		check(int_oe, 1'b0);
		wr(5'h12, 16'h0001);
		check(int_oe, 1'b1);
	endtask : t_polarity

	task automatic t_pdown();
		wr(5'h11, 16'h0002);
		int_ext = 1'b0;
		tick(5);
		check(power_down, 1'b1);
		check(int_oe, 1'b0);
		int_ext = 1'b1;
		tick(5);
		check(power_down, 1'b0);
	endtask : t_pdown

	task automatic t_rereset();
		wr(5'h11, 16'h0101);
		do_reset(8'h3a);
		check(strap_val, 8'h3a);
		check(int_oe, 1'b0);
		rdreg(5'h11);
		check(rd, 16'h0000);
		i_sta.xfer(1'b1, 5'h05, 5'h13, 16'h0000, rd);
		check(rd, 16'hffff);
	endtask : t_rereset

	initial begin
		t_reset();
		t_enable();
		t_polarity();
		t_pdown();
		t_rereset();
		conclude();
	end
endmodule : tb
